//--- hdl/nvbm_pkg.sv
`default_nettype none
package nvbm_pkg;
   // array shape
   localparam int LOC_W = 15;
   localparam int MEM_DEPTH = 32768;
   localparam int DATA_W = 8;
   localparam logic [14:0] LOC_LAST = 15'h7FFF;
   localparam logic [14:0] LOC_FIRST = 15'h0000;

   // write buffer between the bus side and the array: location plus data
   localparam int FIFO_W = LOC_W + DATA_W;
   localparam int FIFO_D = 8;

   // first byte after a start: type nibble, select bits, direction
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int DIR_BIT = 0;
   localparam logic [3:0] MEM_TYPE = 4'hA;
   // identification and sleep target type, value arbitrary
   localparam logic [3:0] ID_TYPE = 4'hF;
   // sleep request byte sent to the identification target, value arbitrary
   localparam logic [7:0] SLEEP_CMD = 8'h86;
   // identification bytes: maker, density, revision; value arbitrary
   localparam logic [23:0] DEVICE_ID = 24'h5A_3C_01;
   localparam logic [1:0] ID_LAST = 2'h2;

   // bit counter marks: eight data rises, ninth is the acknowledge clock
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [3:0] CNT_END = 4'h9;

   // input sampler layout
   localparam int SMP_W = 6;
   localparam int SMP_SCL = 0;
   localparam int SMP_SDA = 1;
   localparam int SMP_SEL = 2;
   localparam int SMP_WP = 5;
   localparam logic [5:0] SMP_RST = 6'h03;

   // bus-side sequencer, one-hot
   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_DEVADR = 8'h02,
      ST_LOCHI  = 8'h04,
      ST_LOCLO  = 8'h08,
      ST_WDATA  = 8'h10,
      ST_RDATA  = 8'h20,
      ST_IDCMD  = 8'h40,
      ST_IGNORE = 8'h80
   } nvbm_st_t;
endpackage
`default_nettype wire

//--- hdl/nvbm_ram.sv
`timescale 1ns/1ps
`default_nettype none
module nvbm_ram #(
   parameter int AW = nvbm_pkg::LOC_W,
   parameter int DW = nvbm_pkg::DATA_W,
   parameter int DEPTH = nvbm_pkg::MEM_DEPTH
) (
   input wire logic mclk, // system clock
   input wire logic en, // port enable
   input wire logic we, // write when enabled
   input wire logic [AW-1:0] addr, // location
   input wire logic [DW-1:0] wdata, // byte to store
   output logic [DW-1:0] rdata // registered read byte
);
   import nvbm_pkg::*;

   logic [DW-1:0] mem [DEPTH];

   // single port; array holds no reset since it models stored content
   always_ff @(posedge mclk) begin
      if (en && we) begin
         mem[addr] <= wdata;
      end
      if (en && !we) begin
         rdata <= mem[addr];
      end
   end
endmodule
`default_nettype wire

//--- hdl/nvbm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module nvbm_fifo #(
   parameter int W = nvbm_pkg::FIFO_W,
   parameter int D = nvbm_pkg::FIFO_D
) (
   input wire logic mclk, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic in_valid, // producer offers a word
   output logic in_ready, // room for a word
   input wire logic [W-1:0] in_data, // word in
   output logic out_valid, // a word is waiting
   input wire logic out_ready, // consumer takes the word
   output logic [W-1:0] out_data // oldest word
);
   import nvbm_pkg::*;

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } nvbm_fifo_t;

   nvbm_fifo_t regs_q;
   nvbm_fifo_t regs_d;
   logic [AW:0] fill;

   // extra pointer bit tells full from empty without a counter
   assign fill = regs_q.wp - regs_q.rp;
   assign in_ready = (fill != (AW+1)'(D));
   assign out_valid = (fill != '0);
   assign out_data = regs_q.mem[regs_q.rp[AW-1:0]];

   always_comb begin
      regs_d = regs_q;
      if (in_valid && in_ready) begin
         regs_d.mem[regs_q.wp[AW-1:0]] = in_data;
         regs_d.wp = regs_q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         regs_d.rp = regs_q.rp + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         regs_q <= '0;
      end else begin
         regs_q <= regs_d;
      end
   end
endmodule
`default_nettype wire

//--- hdl/nvbm_top.sv
// How it works
// RULE1: array of 32768 bytes behind the serial target
// RULE2: answer only when address select bits equal the select pins
// RULE3: floating select pins read low, pulled down outside the core
// RULE4: data line only pulled low or released, never driven high
// RULE5: take bits on clock rise, change driven bits after clock fall
// RULE6: protect input high blocks every array write; low allows all
// RULE7: floating protect input reads low, so array stays writable
// RULE8: each acknowledged data byte goes to the array at once
// RULE9: no busy state; ready for a new transaction right after a write
// RULE10: read-only identification bytes for maker, density and revision
// RULE11: oversampled bus works at 100 kHz, 400 kHz and high speed
// RULE12: sleep entered on the sleep byte acknowledge, stop not needed
// RULE13: address byte is type 1010, select bits 3-1, read flag bit 0
// RULE14: write sends two location bytes; low 15 bits used, top ignored
// RULE15: location advances after each byte, wraps 7FFF to 0, no limit
// RULE16: reads continue while master acknowledges, end on its no-ack
// RULE17: unselected part keeps data line released until next start
`timescale 1ns/1ps
`default_nettype none
module nvbm_top (
   input wire logic mclk, // 40 MHz system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic scl_i, // bus clock pin level
   input wire logic sda_i, // bus data pin level
   output logic sda_o, // data drive level, always low
   output logic sda_oe, // high while pulling data low
   input wire logic [2:0] device_select_pins, // strap select levels
   input wire logic write_protect, // high blocks array writes
   output logic sleep_o // device asleep
);
   import nvbm_pkg::*;

   typedef struct packed {
      logic [SMP_W-1:0] s1;
      logic [SMP_W-1:0] s2;
      logic scl_p;
      logic sda_p;
      nvbm_st_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] hi;
      logic [7:0] tx;
      logic [LOC_W-1:0] loc;
      logic [LOC_W-1:0] ra;
      logic rd;
      logic cap;
      logic oe;
      logic id_mode;
      logic [1:0] id_idx;
      logic sleep;
   } nvbm_regs_t;

   localparam nvbm_regs_t REGS_RST = '{s1: SMP_RST, s2: SMP_RST, scl_p: 1'b1,
      sda_p: 1'b1, st: ST_IDLE, default: '0};

   nvbm_regs_t regs_q;
   nvbm_regs_t regs_d;

   logic scl_s, sda_s, wp_s;
   logic [2:0] sel_s;
   logic rise, fall, start, stop;
   logic push;
   logic [FIFO_W-1:0] push_data;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
   logic [FIFO_W-1:0] fifo_out_data;
   logic ram_en, ram_we;
   logic [LOC_W-1:0] ram_addr;
   logic [DATA_W-1:0] ram_rdata;

   // identification byte by index
   function automatic logic [7:0] id_byte(input logic [1:0] idx);
      case (idx)
         2'h0: id_byte = DEVICE_ID[23:16];
         2'h1: id_byte = DEVICE_ID[15:8];
         default: id_byte = DEVICE_ID[7:0];
      endcase
   endfunction

   // address byte match against type and strapped select levels
   function automatic logic addr_hit(input logic [7:0] b, input logic [3:0] typ,
                                     input logic [2:0] sel);
      addr_hit = (b[TYPE_MSB:TYPE_LSB] == typ) && (b[SEL_MSB:SEL_LSB] == sel);
   endfunction

   // second sampler stage only; pins float low through outside pull-downs
   assign scl_s = regs_q.s2[SMP_SCL]; // [RULE11]
   assign sda_s = regs_q.s2[SMP_SDA];
   assign sel_s = regs_q.s2[SMP_SEL +: 3]; // [RULE3]
   assign wp_s = regs_q.s2[SMP_WP]; // [RULE7]

   // bus events seen at mclk; 3.4 MHz leaves about 6 samples per high phase
   assign rise = scl_s & ~regs_q.scl_p; // [RULE5]
   assign fall = ~scl_s & regs_q.scl_p;
   assign start = scl_s & regs_q.scl_p & regs_q.sda_p & ~sda_s;
   assign stop = scl_s & regs_q.scl_p & ~regs_q.sda_p & sda_s;

   // open drain: the level is fixed low, only the enable moves
   assign sda_o = 1'b0; // [RULE4]
   assign sda_oe = regs_q.oe;
   assign sleep_o = regs_q.sleep;

   // array port: a read fetch takes the port, buffered writes wait a cycle
   assign fifo_out_ready = ~regs_q.rd;
   assign ram_en = regs_q.rd | fifo_out_valid;
   assign ram_we = ~regs_q.rd & fifo_out_valid; // [RULE8]
   assign ram_addr = regs_q.rd ? regs_q.ra : fifo_out_data[FIFO_W-1:DATA_W];

   always_comb begin
      regs_d = regs_q;
      push = 1'b0;
      push_data = {regs_q.loc, regs_q.sh};
      regs_d.s1 = {write_protect, device_select_pins, sda_i, scl_i};
      regs_d.s2 = regs_q.s1;
      regs_d.scl_p = scl_s;
      regs_d.sda_p = sda_s;
      regs_d.rd = 1'b0;
      regs_d.cap = regs_q.rd;
      if (regs_q.cap) begin
         regs_d.tx = ram_rdata;
      end
      if (start) begin
         // a start aborts anything in progress
         regs_d.st = ST_DEVADR;
         regs_d.cnt = '0;
         regs_d.oe = 1'b0;
      end else if (stop) begin
         // no write backlog to wait for, so idle at once
         regs_d.st = ST_IDLE; // [RULE9]
         regs_d.cnt = '0;
         regs_d.oe = 1'b0;
      end else if (regs_q.st == ST_IDLE) begin
         regs_d.cnt = '0;
      end else if (rise) begin
         if (regs_q.st == ST_IGNORE) begin
            // only finish a pending acknowledge clock
            if (regs_q.cnt == CNT_ACK) begin
               regs_d.cnt = CNT_END;
            end
         end else begin
            if (regs_q.cnt < CNT_ACK) begin
               regs_d.sh = {regs_q.sh[6:0], sda_s}; // [RULE5]
            end
            // our own address acknowledge clock carries no master answer
            if (regs_q.st == ST_RDATA && regs_q.cnt == CNT_ACK && !regs_q.oe) begin
               if (sda_s) begin
                  regs_d.st = ST_IGNORE; // [RULE16]
               end else if (regs_q.id_mode) begin
                  regs_d.tx = id_byte(regs_q.id_idx); // [RULE10]
                  regs_d.id_idx = (regs_q.id_idx == ID_LAST) ? 2'h0 : regs_q.id_idx + 2'h1;
               end else begin
                  regs_d.rd = 1'b1; // [RULE16]
                  regs_d.ra = regs_q.loc;
                  regs_d.loc = regs_q.loc + 1'b1; // [RULE15]
               end
            end
            regs_d.cnt = regs_q.cnt + 4'h1;
         end
      end else if (fall && regs_q.cnt == CNT_END) begin
         // end of acknowledge slot: release, or put out the next msb
         regs_d.cnt = '0;
         regs_d.oe = (regs_q.st == ST_RDATA) ? ~regs_q.tx[7] : 1'b0; // [RULE5]
      end else if (fall && regs_q.st == ST_RDATA) begin
         if (regs_q.cnt < CNT_ACK) begin
            regs_d.tx = {regs_q.tx[6:0], 1'b0};
            regs_d.oe = ~regs_q.tx[6]; // [RULE4]
         end else begin
            regs_d.oe = 1'b0;
         end
      end else if (fall && regs_q.st != ST_IGNORE && regs_q.cnt == CNT_ACK) begin
         // whole byte received; decide the acknowledge
         case (regs_q.st)
            ST_DEVADR: begin
               if (addr_hit(regs_q.sh, MEM_TYPE, sel_s)) begin // [RULE2] [RULE13]
                  regs_d.oe = 1'b1;
                  regs_d.id_mode = 1'b0;
                  regs_d.sleep = 1'b0;
                  if (regs_q.sh[DIR_BIT]) begin
                     regs_d.st = ST_RDATA;
                     regs_d.rd = 1'b1; // reads use the current location
                     regs_d.ra = regs_q.loc;
                     regs_d.loc = regs_q.loc + 1'b1; // [RULE15]
                  end else begin
                     regs_d.st = ST_LOCHI;
                  end
               end else if (addr_hit(regs_q.sh, ID_TYPE, sel_s)) begin
                  regs_d.oe = 1'b1;
                  regs_d.id_mode = 1'b1;
                  regs_d.sleep = 1'b0;
                  if (regs_q.sh[DIR_BIT]) begin
                     regs_d.st = ST_RDATA;
                     regs_d.tx = id_byte(2'h0); // [RULE10]
                     regs_d.id_idx = 2'h1;
                  end else begin
                     regs_d.st = ST_IDCMD;
                  end
               end else begin
                  regs_d.st = ST_IGNORE; // [RULE17]
               end
            end
            ST_LOCHI: begin
               regs_d.hi = regs_q.sh;
               regs_d.oe = 1'b1;
               regs_d.st = ST_LOCLO;
            end
            ST_LOCLO: begin
               // top bit of the high byte is dropped
               regs_d.loc = {regs_q.hi[6:0], regs_q.sh}; // [RULE14]
               regs_d.oe = 1'b1;
               regs_d.st = ST_WDATA;
            end
            ST_WDATA: begin
               if (fifo_in_ready) begin
                  // protected bytes are acknowledged but never stored
                  push = ~wp_s; // [RULE6] [RULE8]
                  regs_d.oe = 1'b1;
                  regs_d.loc = regs_q.loc + 1'b1; // [RULE15]
               end else begin
                  regs_d.st = ST_IGNORE; // buffer full: no-ack
               end
            end
            ST_IDCMD: begin
               // identification cannot be written; only the sleep byte is taken
               if (regs_q.sh == SLEEP_CMD) begin
                  regs_d.oe = 1'b1;
                  regs_d.sleep = 1'b1; // [RULE12]
               end
               regs_d.st = ST_IGNORE;
            end
            default: begin
               regs_d.st = ST_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         regs_q <= REGS_RST;
      end else begin
         regs_q <= regs_d;
      end
   end

   // write buffer decouples the bus from the array port
   nvbm_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // storage array, 32768 bytes
   nvbm_ram #(.AW(LOC_W), .DW(DATA_W), .DEPTH(MEM_DEPTH)) u_ram ( // [RULE1]
      .mclk(mclk),
      .en(ram_en),
      .we(ram_we),
      .addr(ram_addr),
      .wdata(fifo_out_data[DATA_W-1:0]),
      .rdata(ram_rdata)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   drive_open_a: assert property (sda_oe |-> sda_o == 1'b0) // [RULE4]
      else $error("data line driven high");
   oe_after_fall_a: assert property ($changed(sda_oe) && !$past(start) // [RULE5]
      && !$past(stop) |-> $past(fall))
      else $error("data drive changed away from a clock fall");
   // nothing may reach the write buffer from a protected byte
   wp_block_a: assert property (regs_q.st == ST_WDATA && fall // [RULE6]
      && regs_q.cnt == CNT_ACK && wp_s |=> !fifo_out_valid)
      else $error("write accepted while protected");
   push_ack_a: assert property (push |=> sda_oe ##0 fifo_out_valid) // [RULE8]
      else $error("received byte not acked or not buffered");
   loc_wrap_a: assert property ($past(regs_q.loc) == LOC_LAST // [RULE15]
      && $changed(regs_q.loc) && $past(regs_q.st) != ST_LOCLO |-> regs_q.loc == LOC_FIRST)
      else $error("location did not wrap to zero");
   stop_idle_a: assert property (stop |=> regs_q.st == ST_IDLE && !sda_oe) // [RULE9]
      else $error("not ready after stop");
   miss_release_a: assert property (regs_q.st == ST_DEVADR && fall // [RULE2]
      && regs_q.cnt == CNT_ACK && !addr_hit(regs_q.sh, MEM_TYPE, sel_s)
      && !addr_hit(regs_q.sh, ID_TYPE, sel_s) |=> regs_q.st == ST_IGNORE && !sda_oe)
      else $error("responded to a foreign address");
   ignore_quiet_a: assert property (regs_q.st == ST_IGNORE // [RULE17]
      && !regs_q.sleep |-> !sda_oe)
      else $error("ignored transfer drives the line");
   read_nack_a: assert property (regs_q.st == ST_RDATA && rise // [RULE16]
      && regs_q.cnt == CNT_ACK && sda_s |=> regs_q.st == ST_IGNORE ##1 !regs_q.rd)
      else $error("read continued after no-ack");
   sleep_enter_a: assert property (regs_q.st == ST_IDCMD && fall // [RULE12]
      && regs_q.cnt == CNT_ACK && regs_q.sh == SLEEP_CMD |=> sleep_o)
      else $error("sleep request not taken");

   write_byte_c: cover property (push ##[1:4] ram_we);
   read_more_c: cover property (regs_q.st == ST_RDATA && rise && regs_q.cnt == CNT_ACK
      && !sda_s && !regs_q.oe);
   sleep_c: cover property ($rose(sleep_o));
endmodule
`default_nettype wire

//--- tb/nvbm_master.sv
`timescale 1ns/1ps
`default_nettype none
module nvbm_master (
   input wire logic mclk, // bench clock, only to place frames off its edges
   output logic scl, // bus clock, driven by the master
   output logic sda_oe_m, // high while the master pulls data low
   input wire logic sda // resolved data line
);
   // clock stands high between frames; bit time 200 ns, 125 low then 75 high
   initial begin
      scl = 1'b1;
      sda_oe_m = 1'b0;
   end
   // start from idle, or repeated start once the target has let go of the line
   task automatic start();
      @(posedge mclk);
      #3;
      if (scl === 1'b0) begin
         #100 sda_oe_m = 1'b0;
         #50 scl = 1'b1;
         #50;
      end
      sda_oe_m = 1'b1;
      #50 scl = 1'b0;
   endtask
   task automatic stop();
      #50 sda_oe_m = 1'b1;
      #75 scl = 1'b1;
      #50 sda_oe_m = 1'b0;
      #100;
   endtask
   // one clock: data set mid-low, sampled 40 ns into the high phase
   task automatic bit_cycle(input logic b, output logic seen);
      #50 sda_oe_m = !b;
      #75 scl = 1'b1;
      #40 seen = sda;
      #35 scl = 1'b0;
   endtask
   // byte out MSB first, address and location bytes included
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s);
      ack = !s;
   endtask
   task automatic rbyte(input logic ack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b1, s);
         b[i] = s;
      end
      bit_cycle(!ack, s); // acknowledge keeps the read going, release ends it
   endtask
endmodule
`default_nettype wire

//--- tb/nvbm_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nvbm_top_tb;
   import nvbm_pkg::*;
   logic mclk;
   logic srst;
   logic [2:0] device_select_pins;
   logic write_protect;
   wire logic scl;
   wire logic m_oe;
   wire logic sda;
   logic sda_o;
   logic sda_oe;
   logic sleep_o;
   int error_cnt;
   int tests_run;
   logic [2:0] cur_sel;
   logic quiet;
   logic oe_prev;
   logic scl_prev;

   // pull-up: a released line reads high
   assign sda = !(sda_oe | m_oe);

   nvbm_top dut (.mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .device_select_pins(device_select_pins),
      .write_protect(write_protect), .sleep_o(sleep_o));
   nvbm_master m (.mclk(mclk), .scl(scl), .sda_oe_m(m_oe), .sda(sda));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // line watch: only pulls low, moves only while clock low, silent when unselected
   always @(posedge mclk) begin
      if (!srst) begin
         if (sda_oe === 1'b1 && sda_o !== 1'b0) begin
            error_cnt++;
            $display("Error sda_o expected 0 seen %b", sda_o);
         end
         if (scl === 1'b1 && scl_prev === 1'b1 && sda_oe !== oe_prev) begin
            error_cnt++;
            $display("Error sda_oe expected %b seen %b", oe_prev, sda_oe);
         end
         if (quiet === 1'b1 && sda_oe !== 1'b0) begin
            error_cnt++;
            $display("Error sda_oe expected 0 seen %b", sda_oe);
         end
      end
      oe_prev <= sda_oe;
      scl_prev <= scl;
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      m.wbyte(b, a);
      chk("ack", {7'h0, exp_ack}, {7'h0, a});
   endtask

   task automatic set_loc(input logic [15:0] loc);
      m.start();
      send({MEM_TYPE, cur_sel, 1'b0}, 1'b1);
      send(loc[15:8], 1'b1);
      send(loc[7:0], 1'b1);
   endtask

   task automatic wr_seq(input logic [15:0] loc, input logic [7:0] base, input int n);
      set_loc(loc);
      for (int i = 0; i < n; i++) send(base + 8'(i), 1'b1);
      m.stop();
   endtask

   // random read: location bytes, repeated start, then n bytes of base+i
   task automatic rd_seq(input logic [15:0] loc, input logic [7:0] base, input int n);
      logic [7:0] d;
      set_loc(loc);
      m.start();
      send({MEM_TYPE, cur_sel, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         m.rbyte(i != n - 1, d);
         chk("read data", base + 8'(i), d);
      end
      m.stop();
   endtask

   task automatic t_write_read();
      wr_seq(16'h8123, 8'h40, 4); // top location bit ignored
      rd_seq(16'h0123, 8'h40, 4); // no busy gap after the write
   endtask

   task automatic t_wrap();
      wr_seq(16'h7FFF, 8'hC0, 3); // last location then 0000
      rd_seq(16'h7FFF, 8'hC0, 3);
      rd_seq(16'h0001, 8'hC2, 1);
   endtask

   task automatic t_protect();
      @(posedge mclk) write_protect <= 1'b1;
      wr_seq(16'h0124, 8'h99, 2); // acked but must not land
      @(posedge mclk) write_protect <= 1'b0;
      rd_seq(16'h0123, 8'h40, 4); // old bytes kept
      wr_seq(16'h0125, 8'h55, 1); // low protect writes again
      rd_seq(16'h0125, 8'h55, 1);
   endtask

   // other strap value: wrong select, then wrong type, both ignored
   task automatic t_select();
      @(posedge mclk) device_select_pins <= 3'h5;
      m.start();
      quiet = 1'b1;
      send({MEM_TYPE, 3'h0, 1'b0}, 1'b0);
      send({MEM_TYPE, 3'h5, 1'b0}, 1'b0); // no new start, still ignored
      m.stop();
      m.start();
      send({4'hB, 3'h5, 1'b1}, 1'b0);
      m.stop();
      quiet = 1'b0;
      cur_sel = 3'h5;
      wr_seq(16'h0200, 8'h11, 1);
      rd_seq(16'h0200, 8'h11, 1);
      cur_sel = 3'h0;
      @(posedge mclk) device_select_pins <= 3'h0; // floating straps read as zeros
   endtask

   task automatic t_ident();
      logic [7:0] d;
      for (int k = 0; k < 2; k++) begin
         m.start();
         send({ID_TYPE, cur_sel, 1'b1}, 1'b1);
         for (int i = 0; i < 3; i++) begin
            m.rbyte(i != 2, d);
            chk("id byte", DEVICE_ID[23 - 8 * i -: 8], d);
         end
         m.stop();
         m.start();
         send({ID_TYPE, cur_sel, 1'b0}, 1'b1);
         send(8'h00, 1'b0); // identification cannot be written
         m.stop();
      end
   endtask

   task automatic t_sleep();
      logic [7:0] d;
      m.start();
      send({ID_TYPE, cur_sel, 1'b0}, 1'b1);
      send(SLEEP_CMD, 1'b1);
      repeat (4) @(posedge mclk);
      #3;
      chk("sleep_o", 8'h01, {7'h0, sleep_o}); // asleep with no stop sent
      m.start();
      send({MEM_TYPE, cur_sel, 1'b1}, 1'b1);
      repeat (4) @(posedge mclk);
      #3;
      chk("sleep_o", 8'h00, {7'h0, sleep_o});
      m.rbyte(1'b0, d);
      m.stop();
   endtask

   // mid-run reset: sleep dropped, location latch back to zero, array kept
   task automatic t_reset();
      logic [7:0] d;
      m.start();
      send({ID_TYPE, cur_sel, 1'b0}, 1'b1);
      send(SLEEP_CMD, 1'b1);
      m.stop();
      @(posedge mclk) srst <= 1'b1;
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      #3;
      chk("sleep_o", 8'h00, {7'h0, sleep_o});
      chk("sda_oe", 8'h00, {7'h0, sda_oe});
      m.start();
      send({MEM_TYPE, cur_sel, 1'b1}, 1'b1);
      m.rbyte(1'b0, d);
      chk("read data", 8'hC1, d); // location 0000 holds the second wrap byte
      m.stop();
   endtask

   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // the whole run needs about 165 us of bus traffic
   initial begin
      #500000;
      error_cnt++;
      $display("Error watchdog expected done seen running");
      print_verdict();
   end

   initial begin
      srst = 1'b1;
      device_select_pins = 3'h0;
      write_protect = 1'b0;
      cur_sel = 3'h0;
      quiet = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      repeat (6) @(posedge mclk);
      srst <= 1'b0;
      repeat (4) @(posedge mclk);
      #3;
      chk("sda_oe", 8'h00, {7'h0, sda_oe});
      chk("sleep_o", 8'h00, {7'h0, sleep_o});
      t_write_read();
      t_wrap();
      t_protect();
      t_select();
      t_ident();
      t_sleep();
      t_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
